// *** trc_timer_regs.vh ***
`ifndef TRC_TIMER_REGS_VH
`define TRC_TIMER_REGS_VH

// ************************************************************
// special function register offsets
// ************************************************************
`define TRC_T0_COUNT_LOW 8'h8a
`define TRC_T0_COUNT_HIGH 8'h8b
`define TRC_T1_COUNT_LOW 8'h8c
`define TRC_T1_COUNT_HIGH 8'h8d
`define TRC_T2_COUNT_LOW 8'h8e
`define TRC_T2_COUNT_HIGH 8'h8f
`define TRC_T0_RELOAD_LOW 8'h92
`define TRC_T0_RELOAD_HIGH 8'h93
`define TRC_T1_RELOAD_LOW 8'h94
`define TRC_T1_RELOAD_HIGH 8'h95
`define TRC_T2_RELOAD_LOW 8'h96
`define TRC_T2_RELOAD_HIGH 8'h97
`define TRC_T0_CONTROL 8'h9a
`define TRC_T1_CONTROL 8'h9b
`define TRC_T2_CONTROL 8'h9c
`define TRC_T0_CLOCK_CONFIG 8'h98
`define TRC_T1_CLOCK_CONFIG 8'h99
`define TRC_T2_CLOCK_CONFIG 8'h9d
`define TRC_DEVICE_IO_MAPPING 8'he1

// ************************************************************
// timer control field positions
// ************************************************************
`define TRC_WRAP_FLAG_BIT 7
`define TRC_TRIGGER_FLAG_BIT 6
`define TRC_COUNT_DOWN_BIT 5
`define TRC_TOGGLE_BIT 4
`define TRC_TRIGGER_ENABLE_BIT 3
`define TRC_RUN_BIT 2
`define TRC_EVENT_COUNT_BIT 1
`define TRC_CAPTURE_BIT 0

// ************************************************************
// clock config field positions
// ************************************************************
`define TRC_CHAIN_BIT 5
`define TRC_OUTPUT_ENABLE_BIT 4
`define TRC_PRESCALE_MSB 3

// ************************************************************
// reset values and counts
// ************************************************************
`define TRC_BYTE_RESET 8'h00
`define TRC_WORD_RESET 16'h0000
`define TRC_COUNT_TOP 16'hffff
`define TRC_COUNT_BOTTOM 16'h0000
`define TRC_CONFIG_MASK_CHAIN 6'h3f
`define TRC_CONFIG_MASK_PLAIN 6'h1f
`define TRC_IO_MAP_MASK 3'h7
`define TRC_PRESCALE_MAX_SHIFT 14

`endif

// *** trc_fall_detect.v ***
module trc_fall_detect (
   // clock and reset
   input wire clock,
   input wire rst,
   // pin level and strobe
   input wire pin_level,
   output reg fall_strobe
);

   // ************************************************************
   // synchroniser and edge detector
   // ************************************************************
   reg sync_first;
   reg sync_second;
   reg sync_prev;

   always @(posedge clock) begin
      if (rst) begin
         sync_first <= 1'b1;
         sync_second <= 1'b1;
         sync_prev <= 1'b1;
         fall_strobe <= 1'b0;
      end else begin
         sync_first <= pin_level;
         sync_second <= sync_first;
         sync_prev <= sync_second;
         fall_strobe <= sync_prev & ~sync_second;
      end
   end

endmodule // trc_fall_detect

// *** trc_prescale.v ***
module trc_prescale #(
   parameter WIDTH = 14
) (
   // clock and reset
   input wire clock,
   input wire rst,
   // division select and tick
   input wire [3:0] divide_select,
   output reg tick
);

   // ************************************************************
   // free running divider, tick every 2**select cycles, select capped at WIDTH
   // ************************************************************
   reg [WIDTH-1:0] divider;
   reg [WIDTH-1:0] mask;
   reg [4:0] shift;

   always @* begin
      shift = {1'b0, divide_select};
      if (shift > WIDTH[4:0])
         shift = WIDTH[4:0];
      mask = ~({WIDTH{1'b1}} << shift);
   end

   always @(posedge clock) begin
      if (rst) begin
         divider <= {WIDTH{1'b0}};
         tick <= 1'b0;
      end else begin
         divider <= divider + {{(WIDTH-1){1'b0}}, 1'b1};
         tick <= (divider & mask) == mask;
      end
   end

endmodule // trc_prescale

// *** trc_timer_block.v ***
`include "trc_timer_regs.vh"

module trc_timer_block #(
   parameter TIMERS = 3,
   parameter PRESCALE_WIDTH = `TRC_PRESCALE_MAX_SHIFT
) (
   // clock and reset
   input wire clock,
   input wire rst,
   // special function register bus
   input wire [7:0] sfr_addr,
   input wire sfr_wr,
   input wire [7:0] sfr_wdata,
   output reg [7:0] sfr_rdata,
   // interrupt enables from the core and requests to it
   input wire [TIMERS-1:0] timer_int_enable,
   output wire [TIMERS-1:0] timer_irq,
   // event input pins, default and alternate
   input wire [TIMERS-1:0] event_input_pin,
   input wire [TIMERS-1:0] event_input_pin_alt,
   // trigger input pins, default and alternate
   input wire [TIMERS-1:0] trigger_input_pin,
   input wire [TIMERS-1:0] trigger_input_pin_alt,
   // timer output pins, default and alternate
   output wire [TIMERS-1:0] timer_out_pin,
   output wire [TIMERS-1:0] timer_out_pin_oe,
   output wire [TIMERS-1:0] timer_out_alt_pin,
   output wire [TIMERS-1:0] timer_out_alt_pin_oe
);

   // ************************************************************
   // shared state
   // ************************************************************
   reg [2:0] device_io_mapping;
   wire [TIMERS-1:0] wrap_bus;
   wire [TIMERS*8-1:0] read_bus;
   reg [7:0] next_rdata;
   integer k;

   // ************************************************************
   // io mapping register, one alternate select per timer
   // ************************************************************
   always @(posedge clock) begin
      if (rst)
         device_io_mapping <= 3'h0;
      else if (sfr_wr && sfr_addr == `TRC_DEVICE_IO_MAPPING)
         device_io_mapping <= sfr_wdata[2:0] & `TRC_IO_MAP_MASK;
   end

   // ************************************************************
   // one timer per generate entry
   // ************************************************************
   genvar i;
   generate
      for (i = 0; i < TIMERS; i = i + 1) begin : tmr
         // ****************************************
         // register addresses of this timer
         // ****************************************
         localparam [7:0] A_CL = (i == 0) ? `TRC_T0_COUNT_LOW :
            (i == 1) ? `TRC_T1_COUNT_LOW : `TRC_T2_COUNT_LOW;
         localparam [7:0] A_CH = (i == 0) ? `TRC_T0_COUNT_HIGH :
            (i == 1) ? `TRC_T1_COUNT_HIGH : `TRC_T2_COUNT_HIGH;
         localparam [7:0] A_RL = (i == 0) ? `TRC_T0_RELOAD_LOW :
            (i == 1) ? `TRC_T1_RELOAD_LOW : `TRC_T2_RELOAD_LOW;
         localparam [7:0] A_RH = (i == 0) ? `TRC_T0_RELOAD_HIGH :
            (i == 1) ? `TRC_T1_RELOAD_HIGH : `TRC_T2_RELOAD_HIGH;
         localparam [7:0] A_CON = (i == 0) ? `TRC_T0_CONTROL :
            (i == 1) ? `TRC_T1_CONTROL : `TRC_T2_CONTROL;
         localparam [7:0] A_CFG = (i == 0) ? `TRC_T0_CLOCK_CONFIG :
            (i == 1) ? `TRC_T1_CLOCK_CONFIG : `TRC_T2_CLOCK_CONFIG;
         localparam [5:0] CFG_MASK = (i == 2) ?
            `TRC_CONFIG_MASK_CHAIN : `TRC_CONFIG_MASK_PLAIN;

         // ****************************************
         // state of this timer
         // ****************************************
         reg [15:0] count;
         reg [15:0] reload;
         reg [7:0] timer_control;
         reg [5:0] timer_clock_config;
         reg toggle_level;
         reg out_level;
         reg out_oe;
         reg out_alt_oe;
         reg irq;
         reg [15:0] next_count;
         wire event_fall;
         wire trigger_fall;
         wire tick;
         wire use_alt = device_io_mapping[i];
         wire event_level;
         wire trigger_level;

         // ****************************************
         // pin selection, default or alternate
         // ****************************************
         assign event_level = use_alt ? event_input_pin_alt[i] :
            event_input_pin[i];
         assign trigger_level = use_alt ? trigger_input_pin_alt[i] :
            trigger_input_pin[i];

         // ****************************************
         // edge detectors and prescaler
         // ****************************************
         trc_fall_detect u_event (
            .clock(clock),
            .rst(rst),
            .pin_level(event_level),
            .fall_strobe(event_fall)
         );

         trc_fall_detect u_trigger (
            .clock(clock),
            .rst(rst),
            .pin_level(trigger_level),
            .fall_strobe(trigger_fall)
         );

         trc_prescale #(
            .WIDTH(PRESCALE_WIDTH)
         ) u_prescale (
            .clock(clock),
            .rst(rst),
            .divide_select(timer_clock_config[`TRC_PRESCALE_MSB:0]),
            .tick(tick)
         );

         // ****************************************
         // control fields, identical for every timer except the chain select, which only timer 2 has
         // ****************************************
         wire run = timer_control[`TRC_RUN_BIT];
         wire count_down_select = timer_control[`TRC_COUNT_DOWN_BIT];
         wire event_count_select = timer_control[`TRC_EVENT_COUNT_BIT];
         wire trigger_pin_enable = timer_control[`TRC_TRIGGER_ENABLE_BIT];
         wire capture_not_reload = timer_control[`TRC_CAPTURE_BIT];
         wire toggle_select = timer_control[`TRC_TOGGLE_BIT];
         wire chain_clock_select = (i == 2) &&
            timer_clock_config[`TRC_CHAIN_BIT];
         wire output_pin_enable =
            timer_clock_config[`TRC_OUTPUT_ENABLE_BIT];

         // ****************************************
         // step source
         // ****************************************
         wire chain_step = (i == 2) ? wrap_bus[1] : 1'b0;
         wire source = event_count_select ? event_fall :
            chain_clock_select ? chain_step : tick;
         wire step = run & source;
         wire wrap = step & (count_down_select ?
            (count == `TRC_COUNT_BOTTOM) : (count == `TRC_COUNT_TOP));
         wire trigger = trigger_pin_enable & event_count_select &
            trigger_fall;
         wire reload_mode = trigger_pin_enable & ~capture_not_reload;
         wire wrap_set = wrap & ~reload_mode;

         // ****************************************
         // bus strobes
         // ****************************************
         wire wr_cl = sfr_wr && sfr_addr == A_CL;
         wire wr_ch = sfr_wr && sfr_addr == A_CH;
         wire wr_rl = sfr_wr && sfr_addr == A_RL;
         wire wr_rh = sfr_wr && sfr_addr == A_RH;
         wire wr_con = sfr_wr && sfr_addr == A_CON;
         wire wr_cfg = sfr_wr && sfr_addr == A_CFG;

         // ****************************************
         // wrap handed to the chained timer
         // ****************************************
         assign wrap_bus[i] = wrap;

         // ****************************************
         // next count: write, trigger reload, wrap, step
         // ****************************************
         always @* begin
            next_count = count;
            if (wr_cl || wr_ch) begin
               if (wr_cl)
                  next_count[7:0] = sfr_wdata;
               if (wr_ch)
                  next_count[15:8] = sfr_wdata;
            end else if (trigger && !capture_not_reload) begin
               next_count = reload;
            end else if (wrap) begin
               next_count = reload;
            end else if (step) begin
               if (count_down_select)
                  next_count = count - 16'h0001;
               else
                  next_count = count + 16'h0001;
            end
         end

         // ****************************************
         // register updates
         // ****************************************
         always @(posedge clock) begin
            if (rst) begin
               count <= `TRC_WORD_RESET;
               reload <= `TRC_WORD_RESET;
               timer_control <= `TRC_BYTE_RESET;
               timer_clock_config <= 6'h00;
               toggle_level <= 1'b0;
               out_level <= 1'b0;
               out_oe <= 1'b0;
               out_alt_oe <= 1'b0;
               irq <= 1'b0;
            end else begin
               count <= next_count;
               if (trigger && capture_not_reload) begin
                  reload <= count;
               end else begin
                  if (wr_rl)
                     reload[7:0] <= sfr_wdata;
                  if (wr_rh)
                     reload[15:8] <= sfr_wdata;
               end
               // wrap flag: hardware set wins, clear needs run
               timer_control[7] <= wrap_set | (wr_con ?
                  (sfr_wdata[7] | (timer_control[7] & ~run)) :
                  timer_control[7]);
               // trigger flag: hardware set wins over a write
               timer_control[6] <= trigger | (wr_con ?
                  sfr_wdata[6] : timer_control[6]);
               if (wr_con)
                  timer_control[5:0] <= sfr_wdata[5:0];
               // reserved clock config bits stay zero
               if (wr_cfg)
                  timer_clock_config <= sfr_wdata[5:0] & CFG_MASK;
               irq <= timer_int_enable[i] & timer_control[7];
               toggle_level <= toggle_level ^ wrap;
               out_level <= toggle_select ?
                  (toggle_level ^ wrap) : wrap;
               out_oe <= output_pin_enable & ~use_alt;
               out_alt_oe <= output_pin_enable & use_alt;
            end
         end

         // ****************************************
         // pin and interrupt outputs
         // ****************************************
         assign timer_irq[i] = irq;
         assign timer_out_pin[i] = out_level;
         assign timer_out_pin_oe[i] = out_oe;
         assign timer_out_alt_pin[i] = out_level;
         assign timer_out_alt_pin_oe[i] = out_alt_oe;

         // ****************************************
         // read mux of this timer
         // ****************************************
         assign read_bus[i*8 +: 8] =
            (sfr_addr == A_CL) ? count[7:0] :
            (sfr_addr == A_CH) ? count[15:8] :
            (sfr_addr == A_RL) ? reload[7:0] :
            (sfr_addr == A_RH) ? reload[15:8] :
            (sfr_addr == A_CON) ? timer_control :
            (sfr_addr == A_CFG) ? {2'b00, timer_clock_config} :
            8'h00;
      end
   endgenerate

   // ************************************************************
   // read data, unmapped addresses read zero
   // ************************************************************
   always @* begin
      next_rdata = 8'h00;
      for (k = 0; k < TIMERS; k = k + 1)
         next_rdata = next_rdata | read_bus[k*8 +: 8];
      if (sfr_addr == `TRC_DEVICE_IO_MAPPING)
         next_rdata = next_rdata | {5'h00, device_io_mapping};
   end

   // ************************************************************
   // registered read data, one cycle behind the address
   // ************************************************************
   always @(posedge clock) begin
      if (rst)
         sfr_rdata <= 8'h00;
      else
         sfr_rdata <= next_rdata;
   end

endmodule // trc_timer_block

// *** trc_core_model.sv ***
module trc_core_model (
   // clock
   input wire clock,
   // register bus
   output logic [7:0] sfr_addr,
   output logic sfr_wr,
   output logic [7:0] sfr_wdata,
   input wire [7:0] sfr_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      sfr_addr = 8'h00;
      sfr_wr = 1'b0;
      sfr_wdata = 8'h00;
   end
   // one-cycle write strobe, taken at the second edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      sfr_addr <= a;
      sfr_wr <= 1'b1;
      sfr_wdata <= d;
      @(posedge clock);
      sfr_wr <= 1'b0;
   endtask
   // read data is registered one cycle behind the address
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      sfr_addr <= a;
      @(posedge clock);
      #1;
      d = sfr_rdata;
   endtask
endmodule // trc_core_model

// *** trc_timer_properties.sv ***
module trc_timer_props #(
   parameter TIMERS = 3
) (
   // clock and reset
   input wire clock,
   input wire rst,
   // register bus
   input wire [7:0] sfr_addr,
   input wire sfr_wr,
   input wire [7:0] sfr_wdata,
   input wire [7:0] sfr_rdata,
   // interrupts
   input wire [TIMERS-1:0] timer_int_enable,
   input wire [TIMERS-1:0] timer_irq,
   // outputs
   input wire [TIMERS-1:0] timer_out_pin,
   input wire [TIMERS-1:0] timer_out_pin_oe,
   input wire [TIMERS-1:0] timer_out_alt_pin_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // ************
   // shadow of timer 2 settings
   // ************
   reg run2;
   reg tog2;
   reg oe2;
   always @(posedge clock) begin
      if (rst) begin
         run2 <= 1'b0;
         tog2 <= 1'b0;
         oe2 <= 1'b0;
      end else if (sfr_wr && sfr_addr == 8'h9c) begin
         run2 <= sfr_wdata[2];
         tog2 <= sfr_wdata[4];
      end else if (sfr_wr && sfr_addr == 8'h9d) begin
         oe2 <= sfr_wdata[4];
      end
   end
   wire ctl_wr = sfr_wr && sfr_addr == 8'h9c;
   sequence s_rl_wr;
      sfr_wr && sfr_addr == 8'h96 ##1 !sfr_wr && sfr_addr == 8'h96;
   endsequence
   sequence s_set_wr;
      ctl_wr && sfr_wdata[7] ##1 timer_int_enable[2] [*2];
   endsequence
   sequence s_clr_idle;
      ctl_wr && !sfr_wdata[7] && !sfr_wdata[2] && !run2 &&
         timer_irq[2] ##1 timer_int_enable[2] [*2];
   endsequence
   property p_reload_rb;
      s_rl_wr |=> sfr_rdata == $past(sfr_wdata, 2);
   endproperty
   a_reload_rb: assert property (p_reload_rb)
      else $error("reload byte readback differs");
   property p_unmapped;
      sfr_addr == 8'h80 |=> sfr_rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_irq_mask;
      1'b1 |=> (timer_irq & ~$past(timer_int_enable)) == '0;
   endproperty
   a_irq_mask: assert property (p_irq_mask)
      else $error("masked interrupt raised");
   property p_irq_set;
      s_set_wr |-> timer_irq[2];
   endproperty
   a_irq_set: assert property (p_irq_set)
      else $error("flag write did not raise interrupt");
   property p_clr_stopped;
      s_clr_idle |-> timer_irq[2];
   endproperty
   a_clr_stopped: assert property (p_clr_stopped)
      else $error("flag cleared while stopped");
   property p_pulse;
      $rose(timer_out_pin[2]) && !tog2 && !$past(tog2) |=>
         !timer_out_pin[2];
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("pulse longer than one cycle");
   property p_oe_off;
      !oe2 && !$past(oe2) |->
         !timer_out_pin_oe[2] && !timer_out_alt_pin_oe[2];
   endproperty
   a_oe_off: assert property (p_oe_off)
      else $error("output driven while disabled");
   property p_one_pin;
      (timer_out_pin_oe & timer_out_alt_pin_oe) == '0;
   endproperty
   a_one_pin: assert property (p_one_pin)
      else $error("both pin mappings driven");
endmodule // trc_timer_props

// *** test_timer_reload_capture_output.sv ***
module test_timer_reload_capture_output;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock;
   logic rst;
   wire [7:0] sfr_addr;
   wire sfr_wr;
   wire [7:0] sfr_wdata;
   wire [7:0] sfr_rdata;
   logic [2:0] int_en;
   logic [2:0] ev_pin;
   logic [2:0] trig_pin;
   wire [2:0] irq;
   wire [2:0] out_pin;
   wire [2:0] out_oe;
   wire [2:0] alt_oe;
   wire [2:0] alt_pin;
   int failures;
   int checked;
   int hi_cycles;
   logic [7:0] regs [8] = '{8'h8e, 8'h8f, 8'h92, 8'h93, 8'h94, 8'h95,
      8'h96, 8'h97};
   trc_timer_block #(.PRESCALE_WIDTH(4)) dut (
      .clock(clock), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .timer_int_enable(int_en), .timer_irq(irq),
      .event_input_pin(ev_pin), .event_input_pin_alt(ev_pin),
      .trigger_input_pin(trig_pin), .trigger_input_pin_alt(trig_pin),
      .timer_out_pin(out_pin), .timer_out_pin_oe(out_oe),
      .timer_out_alt_pin(alt_pin), .timer_out_alt_pin_oe(alt_oe));
   trc_core_model core (.clock(clock), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   always @(posedge clock) begin
      if (out_pin[2] === 1'b1)
         hi_cycles++;
   end
   task automatic check(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rdck(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      core.rd(a, d);
      check($sformatf("reg %h", a), d, e);
   endtask
   // falling edge then rise, long enough for the synchronisers
   task automatic pin_fall(input bit trig);
      @(posedge clock);
      if (trig)
         trig_pin[2] <= 1'b0;
      else
         ev_pin[2] <= 1'b0;
      repeat (4) @(posedge clock);
      trig_pin[2] <= 1'b1;
      ev_pin[2] <= 1'b1;
      repeat (4) @(posedge clock);
   endtask
   task automatic set_count(input logic [15:0] c, input logic [15:0] r);
      core.wr(8'h8e, c[7:0]);
      core.wr(8'h8f, c[15:8]);
      core.wr(8'h96, r[7:0]);
      core.wr(8'h97, r[15:8]);
   endtask
   task automatic complete_run;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #400000;
      failures++;
      complete_run;
   end
   initial begin
      rst = 1'b1;
      int_en = 3'h0;
      ev_pin = 3'h7;
      trig_pin = 3'h7;
      failures = 0;
      checked = 0;
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      foreach (regs[i]) rdck(regs[i], 8'h00);
      rdck(8'h9c, 8'h00);
      for (int i = 0; i < 8; i++) begin
         core.wr(regs[i], 8'h5a ^ 8'(i));
         rdck(regs[i], 8'h5a ^ 8'(i));
      end
      core.wr(8'h80, 8'hff);
      rdck(8'h80, 8'h00);
      $display("test registers done");
      set_count(16'hfffc, 16'h0000);
      core.wr(8'h9d, 8'h10);
      int_en <= 3'h4;
      hi_cycles = 0;
      core.wr(8'h9c, 8'h04);
      repeat (12) @(posedge clock);
      check("irq", {7'h0, irq[2]}, 8'h01);
      check("pulse", 8'(hi_cycles), 8'h01);
      check("oe", {7'h0, out_oe[2]}, 8'h01);
      rdck(8'h8f, 8'h00);
      rdck(8'h9c, 8'h84);
      core.wr(8'h9c, 8'h04);
      repeat (3) @(posedge clock);
      check("irq clr", {7'h0, irq[2]}, 8'h00);
      core.wr(8'h9c, 8'h00);
      core.wr(8'h9c, 8'h80);
      repeat (2) @(posedge clock);
      #1 check("irq set", {7'h0, irq[2]}, 8'h01);
      core.wr(8'h9c, 8'h00);
      rdck(8'h9c, 8'h80);
      core.wr(8'h9c, 8'h04);
      core.wr(8'h9c, 8'h00);
      $display("test overflow done");
      set_count(16'h0002, 16'h1000);
      core.wr(8'h9c, 8'h24);
      repeat (10) @(posedge clock);
      rdck(8'h9c, 8'ha4);
      rdck(8'h8f, 8'h0f);
      core.wr(8'h8f, 8'h20);
      rdck(8'h8f, 8'h20);
      core.wr(8'h9c, 8'h04);
      core.wr(8'h9c, 8'h00);
      $display("test down done");
      set_count(16'h0010, 16'h1000);
      repeat (4) @(posedge clock);
      rdck(8'h8e, 8'h10);
      core.wr(8'h9c, 8'h06);
      repeat (3) pin_fall(1'b0);
      rdck(8'h8e, 8'h13);
      core.wr(8'h8e, 8'h34);
      core.wr(8'h8f, 8'h12);
      core.wr(8'h9c, 8'h07);
      pin_fall(1'b1);
      rdck(8'h97, 8'h10);
      core.wr(8'h9c, 8'h0f);
      pin_fall(1'b1);
      rdck(8'h96, 8'h34);
      rdck(8'h97, 8'h12);
      rdck(8'h9c, 8'h4f);
      core.wr(8'h9c, 8'h0e);
      core.wr(8'h8e, 8'h78);
      core.wr(8'h8f, 8'h56);
      pin_fall(1'b1);
      rdck(8'h8e, 8'h34);
      rdck(8'h8f, 8'h12);
      core.wr(8'h9c, 8'h00);
      $display("test trigger done");
      core.wr(8'he1, 8'h04);
      repeat (2) @(posedge clock);
      check("alt oe", {7'h0, alt_oe[2]}, 8'h01);
      check("def oe", {7'h0, out_oe[2]}, 8'h00);
      core.wr(8'he1, 8'h00);
      set_count(16'hfffc, 16'h0000);
      core.wr(8'h9c, 8'h14);
      repeat (12) @(posedge clock);
      check("toggle", {7'h0, out_pin[2]}, 8'h01);
      check("toggle alt", {7'h0, alt_pin[2]}, 8'h01);
      $display("test map and toggle done");
      core.wr(8'h9c, 8'h00);
      set_count(16'hfffe, 16'h2000);
      core.wr(8'h9c, 8'h0c);
      repeat (6) @(posedge clock);
      rdck(8'h9c, 8'h0c);
      rdck(8'h8f, 8'h20);
      $display("test auto reload done");
      core.wr(8'h9d, 8'h30);
      core.wr(8'h8c, 8'hfe);
      core.wr(8'h8d, 8'hff);
      set_count(16'h0050, 16'h0000);
      core.wr(8'h9c, 8'h04);
      repeat (6) @(posedge clock);
      rdck(8'h8e, 8'h50);
      core.wr(8'h9b, 8'h04);
      repeat (6) @(posedge clock);
      rdck(8'h8e, 8'h51);
      rdck(8'h9b, 8'h84);
      check("irq1 masked", {7'h0, irq[1]}, 8'h00);
      $display("test chain done");
      complete_run;
   end
endmodule // test_timer_reload_capture_output

bind trc_timer_block trc_timer_props #(.TIMERS(TIMERS)) u_props (
   .clock, .rst, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata,
   .timer_int_enable, .timer_irq, .timer_out_pin, .timer_out_pin_oe,
   .timer_out_alt_pin_oe);
